/* pkg/reset_loader_pkg.sv */
package reset_loader_pkg;

    // ****************************************************************
    // post-reset delay, in main clock periods
    // ****************************************************************
    localparam int DELAY_LONG_PERIODS = 131072;
    localparam int DELAY_SHORT_PERIODS = 32768;
    localparam int DELAY_WIDTH = 18;

    // ****************************************************************
    // program counter and reset vector layout
    // ****************************************************************
    localparam int PC_WIDTH_DEFAULT = 13;
    localparam int PMEM_ADDR_WIDTH = 13;
    localparam logic [12:0] VECTOR_HI_ADDR = 13'h0000;
    localparam logic [12:0] VECTOR_LO_ADDR = 13'h0001;
    localparam int REG_BANK_EN_BIT = 6;
    localparam int MEM_BANK_EN_BIT = 7;
    localparam int PC_HI_LSB = 8;

    // ****************************************************************
    // register map, byte addresses
    // ****************************************************************
    localparam logic [7:0] ADDR_EDGE_MODE = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_PC = 8'h08;
    localparam int NOISE_BYPASS_BIT = 2;
    localparam logic [3:0] EDGE_MODE_RESET = 4'h0;

    // status register fields
    localparam int ST_RUN_BIT = 0;
    localparam int ST_WAIT_BIT = 1;
    localparam int ST_WDT_BIT = 2;
    localparam int ST_STANDBY_BIT = 3;

    // ****************************************************************
    // sequencer states
    // ****************************************************************
    typedef enum logic [4:0] {
        SEQ_RESET = 5'b00001,
        SEQ_WAIT = 5'b00010,
        SEQ_FETCH_HI = 5'b00100,
        SEQ_FETCH_LO = 5'b01000,
        SEQ_RUN = 5'b10000
    } seq_state_t;

endpackage

/* rtl/delay_timer.sv */
`timescale 1ns/1ps

module delay_timer #(
    parameter int WIDTH = 18
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control
    input wire logic load,
    input wire logic [WIDTH-1:0] load_value,
    // status
    output logic done
);

    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] next_count;
    logic next_done;

    always_comb begin
        next_count = count;
        if (load) begin
            next_count = load_value;
        end else if (count != '0) begin
            next_count = count - WIDTH'(1);
        end
        next_done = !load && (next_count == '0);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count <= '0;
            done <= 1'b0;
        end else begin
            count <= next_count;
            done <= next_done;
        end
    end

endmodule

/* rtl/reset_and_vector_loader.sv */
`timescale 1ns/1ps

// Contract
// - pin reset or watchdog request, either alone, raises the internal reset.
// - post-reset delay is 2^17 or 2^15 clocks, fixed at build time.
// - 12-bit counter takes word 0 low 4 bits and word 1.
// - 13-bit counter takes word 0 low 5 bits and word 1.
// - word 0 bit 6 sets register bank enable, bit 7 memory bank enable.
// - in standby interrupts 1, 2 and 4 still detect, interrupt 0 not.
// - interrupt 0 works only with noise filter bypass bit set.
// - internal reset clears sequencer, skip and interrupt status flags, edge mode and requests; carry only outside standby.
module reset_and_vector_loader #(
    parameter int PC_WIDTH = reset_loader_pkg::PC_WIDTH_DEFAULT,
    parameter bit LONG_DELAY = 1'b1,
    parameter int DELAY_LONG = reset_loader_pkg::DELAY_LONG_PERIODS,
    parameter int DELAY_SHORT = reset_loader_pkg::DELAY_SHORT_PERIODS
) (
    // clock and system reset
    input wire logic clk,
    input wire logic rst_n,
    // reset sources and mode
    input wire logic ext_reset_n,
    input wire logic wdt_reset_req,
    input wire logic standby,
    // program memory read port
    output logic [reset_loader_pkg::PMEM_ADDR_WIDTH-1:0] pmem_addr,
    input wire logic [7:0] pmem_data,
    // core state
    output logic core_reset,
    output logic cpu_run,
    output logic [PC_WIDTH-1:0] pc,
    output logic register_bank_enable_flag,
    output logic memory_bank_enable_flag,
    output logic [2:0] skip_flags,
    output logic [1:0] interrupt_status_flags,
    output logic carry_flag,
    input wire logic carry_in,
    input wire logic carry_we,
    // external interrupt inputs and gated requests
    input wire logic ext_irq_zero,
    input wire logic ext_irq_one,
    input wire logic ext_irq_two,
    input wire logic ext_irq_four,
    output logic irq_req_zero,
    output logic irq_req_one,
    output logic irq_req_two,
    output logic irq_req_four,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);

    localparam int DW = reset_loader_pkg::DELAY_WIDTH;
    localparam int HI_W = PC_WIDTH - 8;
    // mask option picks the count once; software cannot touch it
    localparam logic [DW-1:0] DELAY_LOAD =
        DW'((LONG_DELAY ? DELAY_LONG : DELAY_SHORT) - 1);

    // ****************************************************************
    // internal reset
    // ****************************************************************
    logic int_reset;
    assign int_reset = !ext_reset_n || wdt_reset_req;

    // ****************************************************************
    // sequencer
    // ****************************************************************
    reset_loader_pkg::seq_state_t state;
    reset_loader_pkg::seq_state_t next_state;
    logic delay_done;
    logic next_core_reset;
    logic next_cpu_run;
    logic [reset_loader_pkg::PMEM_ADDR_WIDTH-1:0] next_pmem_addr;
    logic [7:0] vec_hi;
    logic [7:0] next_vec_hi;
    logic [PC_WIDTH-1:0] next_pc;
    logic next_reg_bank_en;
    logic next_mem_bank_en;
    logic [2:0] next_skip;
    logic [1:0] next_int_status;
    logic next_carry;
    logic standby_reset;
    logic next_standby_reset;
    logic wdt_reset;
    logic next_wdt_reset;

    delay_timer #(
        .WIDTH(DW)
    ) u_delay (
        .clk(clk),
        .rst_n(rst_n),
        .load(state == reset_loader_pkg::SEQ_RESET),
        .load_value(DELAY_LOAD),
        .done(delay_done)
    );

    always_comb begin
        next_state = state;
        next_core_reset = int_reset;
        next_cpu_run = 1'b0;
        next_pmem_addr = reset_loader_pkg::VECTOR_HI_ADDR;
        next_vec_hi = vec_hi;
        next_pc = pc;
        next_reg_bank_en = register_bank_enable_flag;
        next_mem_bank_en = memory_bank_enable_flag;
        next_skip = skip_flags;
        next_int_status = interrupt_status_flags;
        next_carry = carry_flag;
        next_standby_reset = standby_reset;
        next_wdt_reset = wdt_reset;
        if (int_reset) begin
            next_state = reset_loader_pkg::SEQ_RESET;
            next_skip = 3'h0;
            next_int_status = 2'h0;
            // capture cause only on the first cycle of the reset
            if (state != reset_loader_pkg::SEQ_RESET) begin
                next_standby_reset = standby;
                next_wdt_reset = wdt_reset_req;
                // carry undefined after a running reset; zero chosen
                next_carry = standby ? carry_flag : 1'b0;
            end
        end else begin
            unique case (state)
                reset_loader_pkg::SEQ_RESET: begin
                    next_state = reset_loader_pkg::SEQ_WAIT;
                end
                reset_loader_pkg::SEQ_WAIT: begin
                    if (delay_done) begin
                        next_state = reset_loader_pkg::SEQ_FETCH_HI;
                        next_pmem_addr = reset_loader_pkg::VECTOR_LO_ADDR;
                    end
                end
                reset_loader_pkg::SEQ_FETCH_HI: begin
                    // data now shows word 0
                    next_state = reset_loader_pkg::SEQ_FETCH_LO;
                    next_vec_hi = pmem_data;
                    next_reg_bank_en =
                        pmem_data[reset_loader_pkg::REG_BANK_EN_BIT];
                    next_mem_bank_en =
                        pmem_data[reset_loader_pkg::MEM_BANK_EN_BIT];
                end
                reset_loader_pkg::SEQ_FETCH_LO: begin
                    next_state = reset_loader_pkg::SEQ_RUN;
                    next_cpu_run = 1'b1;
                    next_pc = {vec_hi[HI_W-1:0], pmem_data};
                end
                reset_loader_pkg::SEQ_RUN: begin
                    next_cpu_run = 1'b1;
                    next_pmem_addr = pmem_addr;
                    if (carry_we) begin
                        next_carry = carry_in;
                    end
                end
                default: begin
                    next_state = reset_loader_pkg::SEQ_RESET;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= reset_loader_pkg::SEQ_RESET;
            core_reset <= 1'b1;
            cpu_run <= 1'b0;
            pmem_addr <= reset_loader_pkg::VECTOR_HI_ADDR;
            vec_hi <= 8'h00;
            pc <= '0;
            register_bank_enable_flag <= 1'b0;
            memory_bank_enable_flag <= 1'b0;
            skip_flags <= 3'h0;
            interrupt_status_flags <= 2'h0;
            carry_flag <= 1'b0;
            standby_reset <= 1'b0;
            wdt_reset <= 1'b0;
        end else begin
            state <= next_state;
            core_reset <= next_core_reset;
            cpu_run <= next_cpu_run;
            pmem_addr <= next_pmem_addr;
            vec_hi <= next_vec_hi;
            pc <= next_pc;
            register_bank_enable_flag <= next_reg_bank_en;
            memory_bank_enable_flag <= next_mem_bank_en;
            skip_flags <= next_skip;
            interrupt_status_flags <= next_int_status;
            carry_flag <= next_carry;
            standby_reset <= next_standby_reset;
            wdt_reset <= next_wdt_reset;
        end
    end

    // ****************************************************************
    // register bus and edge detection mode register
    // ****************************************************************
    logic [3:0] edge_detect_mode_reg;
    logic [3:0] next_edge_mode;
    logic [31:0] next_dat;
    logic next_ack;
    logic bus_req;
    logic noise_filter_bypass_bit;

    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign noise_filter_bypass_bit =
        edge_detect_mode_reg[reset_loader_pkg::NOISE_BYPASS_BIT];

    always_comb begin
        next_edge_mode = edge_detect_mode_reg;
        next_dat = wb_dat_o;
        next_ack = bus_req;
        if (bus_req) begin
            next_dat = 32'h0000_0000;
            unique case (wb_adr_i)
                reset_loader_pkg::ADDR_EDGE_MODE: begin
                    next_dat[3:0] = edge_detect_mode_reg;
                    if (wb_we_i && wb_sel_i[0]) begin
                        next_edge_mode = wb_dat_i[3:0];
                    end
                end
                reset_loader_pkg::ADDR_STATUS: begin
                    next_dat[reset_loader_pkg::ST_RUN_BIT] = cpu_run;
                    next_dat[reset_loader_pkg::ST_WAIT_BIT] =
                        (state == reset_loader_pkg::SEQ_WAIT);
                    next_dat[reset_loader_pkg::ST_WDT_BIT] = wdt_reset;
                    next_dat[reset_loader_pkg::ST_STANDBY_BIT] =
                        standby_reset;
                end
                reset_loader_pkg::ADDR_PC: begin
                    next_dat[PC_WIDTH-1:0] = pc;
                end
                default: begin
                    // unmapped: acknowledged, reads zero, writes dropped
                    next_dat = 32'h0000_0000;
                end
            endcase
        end
        if (int_reset) begin
            next_edge_mode = reset_loader_pkg::EDGE_MODE_RESET;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            edge_detect_mode_reg <= reset_loader_pkg::EDGE_MODE_RESET;
            wb_dat_o <= 32'h0000_0000;
            wb_ack_o <= 1'b0;
        end else begin
            edge_detect_mode_reg <= next_edge_mode;
            wb_dat_o <= next_dat;
            wb_ack_o <= next_ack;
        end
    end

    // ****************************************************************
    // external interrupt gating
    // ****************************************************************
    logic [3:0] next_irq;

    always_comb begin
        // the filter needs the stopped clock, so line 0 dies in standby
        next_irq[0] = ext_irq_zero && noise_filter_bypass_bit
            && !standby && !int_reset;
        next_irq[1] = ext_irq_one && !int_reset;
        next_irq[2] = ext_irq_two && !int_reset;
        next_irq[3] = ext_irq_four && !int_reset;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_req_zero <= 1'b0;
            irq_req_one <= 1'b0;
            irq_req_two <= 1'b0;
            irq_req_four <= 1'b0;
        end else begin
            irq_req_zero <= next_irq[0];
            irq_req_one <= next_irq[1];
            irq_req_two <= next_irq[2];
            irq_req_four <= next_irq[3];
        end
    end

endmodule

/* bench/pmem_model.sv */
`timescale 1ns/1ps

module pmem_model (
    // clock
    input wire logic clk,
    // read port
    input wire logic [12:0] addr,
    output logic [7:0] data,
    // vector words
    input wire logic [7:0] word0,
    input wire logic [7:0] word1
);
    // one cycle read latency; other places give a changing pattern
    always_ff @(posedge clk) begin
        data <= (addr == 13'h0000) ? word0 :
            (addr == 13'h0001) ? word1 : ~data;
    end
endmodule

/* bench/reset_loader_props.sv */
`timescale 1ns/1ps

module reset_loader_props (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // reset sources
    input wire logic ext_reset_n,
    input wire logic wdt_reset_req,
    input wire logic standby,
    // core state
    input wire logic core_reset,
    input wire logic cpu_run,
    input wire logic [2:0] skip_flags,
    input wire logic [1:0] interrupt_status_flags,
    // interrupts
    input wire logic ext_irq_two,
    input wire logic ext_irq_four,
    input wire logic irq_req_zero,
    input wire logic irq_req_two,
    input wire logic irq_req_four,
    // bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_reset_src: assert property (
        !ext_reset_n || wdt_reset_req |-> ##[1:2] core_reset)
        else $error("internal reset missed");
    chk_reset_state: assert property (
        core_reset && $past(core_reset) |-> !cpu_run &&
        skip_flags == 3'h0 && interrupt_status_flags == 2'h0)
        else $error("state not cleared in reset");
    chk_delay_hold: assert property (
        $fell(core_reset) |-> !cpu_run [*8] ##[1:12]
        (cpu_run || core_reset))
        else $error("run start outside delay window");
    chk_irq_two: assert property (
        standby && ext_irq_two && !core_reset ##1 !core_reset
        |-> irq_req_two)
        else $error("irq two lost in standby");
    chk_irq_four: assert property (
        standby && ext_irq_four && !core_reset ##1 !core_reset
        |-> irq_req_four)
        else $error("irq four lost in standby");
    chk_irq0_sleep: assert property (
        standby |=> !irq_req_zero)
        else $error("irq zero passed in standby");
    chk_irq_reset: assert property (
        core_reset && $past(core_reset) |-> !irq_req_two && !irq_req_four)
        else $error("irq passed in reset");
    chk_ack_pulse: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a single cycle pulse");
endmodule

bind reset_and_vector_loader reset_loader_props u_reset_loader_props (
    .clk(clk), .rst_n(rst_n), .ext_reset_n(ext_reset_n),
    .wdt_reset_req(wdt_reset_req), .standby(standby),
    .core_reset(core_reset), .cpu_run(cpu_run), .skip_flags(skip_flags),
    .interrupt_status_flags(interrupt_status_flags),
    .ext_irq_two(ext_irq_two), .ext_irq_four(ext_irq_four),
    .irq_req_zero(irq_req_zero), .irq_req_two(irq_req_two),
    .irq_req_four(irq_req_four), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o)
);

/* bench/test_reset_and_vector_loader.sv */
`timescale 1ns/1ps

module test_reset_and_vector_loader;
    typedef struct {
        logic sb;
        logic wd;
        logic [7:0] w0;
        logic [7:0] w1;
        logic [12:0] pc;
        logic [11:0] pc12;
    } row_t;
    localparam int N = 16;
    localparam int N_SHORT = 8;
    row_t rows[4] = '{'{1'b0, 1'b0, 8'hC5, 8'h3A, 13'h053A, 12'h053A},
        '{1'b1, 1'b0, 8'h4E, 8'hFF, 13'h0EFF, 12'h0EFF},
        '{1'b0, 1'b1, 8'h9F, 8'h00, 13'h1F00, 12'h0F00},
        '{1'b1, 1'b1, 8'h20, 8'h81, 13'h0081, 12'h0081}};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ext_reset_n = 1'b1;
    logic wdt_reset_req = 1'b0;
    logic standby = 1'b0;
    logic carry_in = 1'b0;
    logic carry_we = 1'b0;
    logic [3:0] irq = 4'h0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0000_0000;
    logic [7:0] word0 = 8'h00;
    logic [7:0] word1 = 8'h00;
    logic [12:0] pmem_addr, pc;
    logic [7:0] pmem_data;
    logic core_reset, cpu_run, reg_bank_en, mem_bank_en, carry, ack;
    logic [12:0] pmem_addr2;
    logic [11:0] pc2;
    logic [7:0] pmem_data2;
    logic cpu_run2;
    int n2;
    logic [2:0] skip;
    logic [1:0] ist;
    logic [3:0] irq_o;
    logic [31:0] rdat, rd;
    int miscompares = 0;
    int tests_run = 0;
    int cycles = 0;
    int n;

    always #4 clk = ~clk;

    reset_and_vector_loader #(.PC_WIDTH(13), .LONG_DELAY(1'b1),
        .DELAY_LONG(N), .DELAY_SHORT(8)) u_reset_and_vector_loader (
        .clk(clk), .rst_n(rst_n), .ext_reset_n(ext_reset_n),
        .wdt_reset_req(wdt_reset_req), .standby(standby),
        .pmem_addr(pmem_addr), .pmem_data(pmem_data),
        .core_reset(core_reset), .cpu_run(cpu_run), .pc(pc),
        .register_bank_enable_flag(reg_bank_en),
        .memory_bank_enable_flag(mem_bank_en),
        .skip_flags(skip), .interrupt_status_flags(ist),
        .carry_flag(carry), .carry_in(carry_in), .carry_we(carry_we),
        .ext_irq_zero(irq[0]), .ext_irq_one(irq[1]),
        .ext_irq_two(irq[2]), .ext_irq_four(irq[3]),
        .irq_req_zero(irq_o[0]), .irq_req_one(irq_o[1]),
        .irq_req_two(irq_o[2]), .irq_req_four(irq_o[3]),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack));

    pmem_model u_pmem_model (.clk(clk), .addr(pmem_addr),
        .data(pmem_data), .word0(word0), .word1(word1));

    // short-delay 12-bit build on the same reset sources
    reset_and_vector_loader #(.PC_WIDTH(12), .LONG_DELAY(1'b0),
        .DELAY_LONG(N), .DELAY_SHORT(N_SHORT))
        u_reset_and_vector_loader_short (
        .clk(clk), .rst_n(rst_n), .ext_reset_n(ext_reset_n),
        .wdt_reset_req(wdt_reset_req), .standby(standby),
        .pmem_addr(pmem_addr2), .pmem_data(pmem_data2),
        .core_reset(), .cpu_run(cpu_run2), .pc(pc2),
        .register_bank_enable_flag(), .memory_bank_enable_flag(),
        .skip_flags(), .interrupt_status_flags(),
        .carry_flag(), .carry_in(carry_in), .carry_we(carry_we),
        .ext_irq_zero(irq[0]), .ext_irq_one(irq[1]),
        .ext_irq_two(irq[2]), .ext_irq_four(irq[3]),
        .irq_req_zero(), .irq_req_one(), .irq_req_two(), .irq_req_four(),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(), .wb_ack_o());

    pmem_model u_pmem_model_short (.clk(clk), .addr(pmem_addr2),
        .data(pmem_data2), .word0(word0), .word1(word1));

    task automatic check(input string what, input logic [31:0] seen,
            input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // called just after an edge; values read there are pre-edge
    task automatic wb(input logic w, input logic [7:0] a,
            input logic [31:0] d);
        int k;
        k = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk);
            k++;
        end while (ack !== 1'b1 && k < 20);
        rd = rdat;
        check("ack", ack, 1);
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wait_run();
        n = 0;
        n2 = 1;
        do begin
            @(posedge clk);
            n++;
            if (cpu_run2 !== 1'b1) begin
                n2 = n + 1;
            end
        end while (cpu_run !== 1'b1 && n < 200);
    endtask

    task automatic pulse_reset(input logic sb, input logic wd);
        standby <= sb;
        wdt_reset_req <= wd;
        ext_reset_n <= wd;
        repeat (3) @(posedge clk);
        wdt_reset_req <= 1'b0;
        ext_reset_n <= 1'b1;
        standby <= 1'b0;
        do @(posedge clk); while (core_reset !== 1'b0);
        wait_run();
        // wait cycles, then the two vector fetch cycles
        check("delay", n, N + 2);
        check("short delay", n2, N_SHORT + 2);
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            print_verdict();
        end
    end

    initial begin
        repeat (6) @(posedge clk);
        check("in reset", {core_reset, cpu_run, skip, ist}, 7'h40);
        rst_n <= 1'b1;
        wait_run();
        foreach (rows[i]) begin
            word0 <= rows[i].w0;
            word1 <= rows[i].w1;
            carry_in <= 1'b1;
            carry_we <= 1'b1;
            @(posedge clk);
            carry_we <= 1'b0;
            @(posedge clk);
            check("carry set", carry, 1);
            pulse_reset(rows[i].sb, rows[i].wd);
            check("pc", pc, rows[i].pc);
            check("pc short", pc2, rows[i].pc12);
            check("bank flags", {mem_bank_en, reg_bank_en},
                rows[i].w0[7:6]);
            check("flags", {skip, ist}, 0);
            check("carry", carry, rows[i].sb);
            wb(1'b0, 8'h04, 32'h0000_0000);
            check("status", rd, {rows[i].sb, rows[i].wd, 2'b01});
            wb(1'b0, 8'h08, 32'h0000_0000);
            check("pc reg", rd, rows[i].pc);
        end
        // reset again in mid delay, full delay must restart
        ext_reset_n <= 1'b0;
        repeat (3) @(posedge clk);
        ext_reset_n <= 1'b1;
        repeat (8) @(posedge clk);
        pulse_reset(1'b0, 1'b0);
        // gating with bypass set, in and out of standby
        irq <= 4'hF;
        wb(1'b1, 8'h00, 32'h0000_0004);
        wb(1'b0, 8'h00, 32'h0000_0000);
        check("edge mode", rd, 4);
        check("irq bypass", irq_o, 4'hF);
        standby <= 1'b1;
        repeat (2) @(posedge clk);
        check("irq standby", irq_o, 4'hE);
        standby <= 1'b0;
        wb(1'b1, 8'h00, 32'h0000_0000);
        check("irq filtered", irq_o, 4'hE);
        wb(1'b1, 8'h3C, 32'hFFFF_FFFF);
        wb(1'b0, 8'h3C, 32'h0000_0000);
        check("unmapped", rd, 0);
        wb(1'b1, 8'h00, 32'h0000_0004);
        pulse_reset(1'b0, 1'b1);
        wb(1'b0, 8'h00, 32'h0000_0000);
        check("mode cleared", rd, 0);
        print_verdict();
    end
endmodule
